// ### orc_pkg.sv
// package of register map, field layout and encodings for the oscillator and reference clock control
package orc_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RC_TUNE = 8'h10;
  localparam logic [7:0] ADDR_REF_CTRL = 8'h20;
  localparam logic [7:0] ADDR_REF_TRIM = 8'h30;
  localparam logic [7:0] ADDR_UNLOCK = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h44;
  // ==========================================================
  // unlock keys, written in order to the unlock register
  localparam logic [31:0] UNLOCK_KEY1 = 32'haa99_6655;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h5566_99aa;
  // ==========================================================
  // oscillator control fields
  localparam int OSC_SWITCH_BIT = 0;
  localparam int SOSC_EN_BIT = 1;
  localparam int USB_RC_BIT = 2;
  localparam int FAIL_FLAG_BIT = 3;
  localparam int NEW_OSC_LSB = 8;
  localparam int OSC_SEL_W = 3;
  localparam int CUR_OSC_LSB = 12;
  localparam logic [2:0] OSC_SEL_RESET = 3'h0;
  // ==========================================================
  // tuning
  localparam int TUNE_W = 6;
  // ==========================================================
  // reference control fields
  localparam int SEL_LSB = 0;
  localparam int SEL_W = 4;
  localparam int ACTIVE_BIT = 8;
  localparam int DIVSW_BIT = 9;
  localparam int RUN_SLEEP_BIT = 11;
  localparam int OE_BIT = 12;
  localparam int STOP_IDLE_BIT = 13;
  localparam int ON_BIT = 15;
  localparam int DIV_LSB = 16;
  localparam int DIV_W = 15;
  localparam int TRIM_LSB = 23;
  localparam int TRIM_W = 9;
  // ==========================================================
  // reference source codes
  localparam logic [3:0] SRC_SYS_CLK = 4'h0;
  localparam logic [3:0] SRC_PERIPH_CLK = 4'h1;
  localparam logic [3:0] SRC_POSC = 4'h2;
  localparam logic [3:0] SRC_FAST_RC = 4'h3;
  localparam logic [3:0] SRC_LOW_POWER_RC = 4'h4;
  localparam logic [3:0] SRC_SOSC = 4'h5;
  localparam logic [3:0] SRC_UPLL = 4'h6;
  localparam logic [3:0] SRC_SPLL = 4'h7;
  localparam logic [3:0] SRC_EXT = 4'h8;
  localparam int NUM_SRC = 9;
  // ==========================================================
  // accumulator width: trim fraction plus one
  localparam int ACC_W = TRIM_W + 1;
  localparam logic [31:0] DIV_CLKS = 32'd2;

  typedef enum logic [2:0] {
    ORC_SW_IDLE = 3'b001,
    ORC_SW_WAIT = 3'b010,
    ORC_SW_DONE = 3'b100
  } orc_sw_e;
endpackage

// ### orc_top.sv
// oscillator control, rc tuning and reference clock generator behind apb
`timescale 1ns/1ps
`default_nettype none

// Operation
// - fail monitor failure sets clock fail flag
// - usb clock select picks rc or primary
// - secondary oscillator runs while enable set
// - switch request starts switch, self clears
// - control and tuning writes need unlock
// - tuning field is signed six bit trim
// - generator runs only while enabled
// - stop in idle halts generator
// - output pin carries clock only when enabled
// - run in sleep keeps output in sleep
// - run in sleep ignored for clock sources
// - divider switch bit busy, hardware cleared
// - source and divider held while enabled
// - trim held while enabled until switch
// - request status bit shows active request
// - four bit source select with reserved codes
// - fifteen bit integer divider field
// - nine bit trim adds n over 512
// - unimplemented bits read zero
// - three bit new oscillator selection
module orc_top #(
  parameter int SWITCH_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fail_safe_clock_monitor,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  input wire logic [8:0] ref_src_clks,
  output logic ref_clock_out_pin,
  output logic ref_clock_out_oe_n,
  output logic usb_clock_from_rc_select,
  output logic secondary_osc_enable,
  output logic [5:0] rc_trim_field,
  output logic [2:0] osc_select,
  output logic osc_switch_pulse
);
  // ==========================================================
  // bus decode
  wire logic access_w = psel & penable;
  wire logic wr_w = access_w & pwrite & clk_en;
  wire logic hit_osc = paddr == orc_pkg::ADDR_OSC_CTRL;
  wire logic hit_tun = paddr == orc_pkg::ADDR_RC_TUNE;
  wire logic hit_ref = paddr == orc_pkg::ADDR_REF_CTRL;
  wire logic hit_trm = paddr == orc_pkg::ADDR_REF_TRIM;
  wire logic hit_unl = paddr == orc_pkg::ADDR_UNLOCK;
  wire logic hit_sts = paddr == orc_pkg::ADDR_STATUS;
  wire logic mapped = hit_osc | hit_tun | hit_ref | hit_trm | hit_unl | hit_sts;

  assign pready = 1'b1;
  assign pslverr = access_w & ~mapped;

  // ==========================================================
  // unlock sequence: key1 then key2 opens one locked write
  logic [1:0] unl_r;
  logic locked_wr_r;
  wire logic key1_w = wr_w & hit_unl & (pwdata == orc_pkg::UNLOCK_KEY1);
  wire logic key2_w = wr_w & hit_unl & (pwdata == orc_pkg::UNLOCK_KEY2) & unl_r[0];
  wire logic unlocked = unl_r[1];
  wire logic osc_wr = wr_w & hit_osc & unlocked;
  wire logic tun_wr = wr_w & hit_tun & unlocked;
  wire logic lock_use = osc_wr | tun_wr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unl_r <= 2'h0;
      locked_wr_r <= 1'b0;
    end else if (clk_en) begin
      // any other unlock-register write or a locked write relocks
      if (key1_w) begin
        unl_r <= 2'h1;
      end else if (key2_w) begin
        unl_r <= 2'h2;
      end else if (lock_use || (wr_w && hit_unl)) begin
        unl_r <= 2'h0;
      end
      // holds until the next control or tuning write so software can poll it
      if (wr_w && (hit_osc || hit_tun)) begin
        locked_wr_r <= ~unlocked;
      end
    end
  end

  // ==========================================================
  // oscillator control
  logic fail_flag_r, usb_rc_r, sosc_r, osw_r;
  logic [2:0] new_osc_r, cur_osc_r;
  logic [5:0] tun_r;
  logic [$clog2(SWITCH_CYCLES+1)-1:0] sw_cnt_r;
  orc_pkg::orc_sw_e sw_st_r;
  wire logic osw_set = osc_wr & pwdata[orc_pkg::OSC_SWITCH_BIT] & ~osw_r;
  wire logic sw_done = sw_st_r == orc_pkg::ORC_SW_DONE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_flag_r <= 1'b0;
      usb_rc_r <= 1'b0;
      sosc_r <= 1'b0;
      new_osc_r <= orc_pkg::OSC_SEL_RESET;
      tun_r <= 6'h00;
    end else if (clk_en) begin
      // set wins over software clear
      if (fail_safe_clock_monitor) begin
        fail_flag_r <= 1'b1;
      end else if (osc_wr) begin
        fail_flag_r <= pwdata[orc_pkg::FAIL_FLAG_BIT];
      end
      if (osc_wr) begin
        usb_rc_r <= pwdata[orc_pkg::USB_RC_BIT];
        sosc_r <= pwdata[orc_pkg::SOSC_EN_BIT];
        new_osc_r <= pwdata[orc_pkg::NEW_OSC_LSB +: orc_pkg::OSC_SEL_W];
      end
      if (tun_wr) begin
        tun_r <= pwdata[orc_pkg::TUNE_W-1:0];
      end
    end
  end

  // switch sequencer: waits a fixed settle time then adopts the new source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_st_r <= orc_pkg::ORC_SW_IDLE;
      sw_cnt_r <= '0;
      osw_r <= 1'b0;
      cur_osc_r <= orc_pkg::OSC_SEL_RESET;
    end else if (clk_en) begin
      unique case (sw_st_r)
        orc_pkg::ORC_SW_IDLE: begin
          if (osw_set) begin
            osw_r <= 1'b1;
            sw_cnt_r <= '0;
            sw_st_r <= orc_pkg::ORC_SW_WAIT;
          end
        end
        orc_pkg::ORC_SW_WAIT: begin
          if (sw_cnt_r == ($bits(sw_cnt_r))'(SWITCH_CYCLES - 1)) begin
            sw_st_r <= orc_pkg::ORC_SW_DONE;
          end else begin
            sw_cnt_r <= sw_cnt_r + 1'b1;
          end
        end
        orc_pkg::ORC_SW_DONE: begin
          cur_osc_r <= new_osc_r;
          osw_r <= 1'b0;
          sw_st_r <= orc_pkg::ORC_SW_IDLE;
        end
        default: sw_st_r <= orc_pkg::ORC_SW_IDLE;
      endcase
    end
  end

  assign usb_clock_from_rc_select = usb_rc_r;
  assign secondary_osc_enable = sosc_r;
  assign rc_trim_field = tun_r;
  assign osc_select = cur_osc_r;
  assign osc_switch_pulse = sw_done;

  // ==========================================================
  // reference clock control; shadow fields hold back writes while on
  logic on_r, stop_idle_r, oe_r, run_sleep_r, dsw_r;
  logic [3:0] sel_sh_r, sel_r;
  logic [14:0] div_sh_r, div_r;
  logic [8:0] trm_sh_r, trm_r;
  wire logic ref_wr = wr_w & hit_ref;
  wire logic trm_wr = wr_w & hit_trm;
  wire logic [3:0] wsel = pwdata[orc_pkg::SEL_LSB +: orc_pkg::SEL_W];
  wire logic [14:0] wdiv = pwdata[orc_pkg::DIV_LSB +: orc_pkg::DIV_W];
  wire logic [8:0] wtrm = pwdata[orc_pkg::TRIM_LSB +: orc_pkg::TRIM_W];
  wire logic dsw_req = ref_wr & pwdata[orc_pkg::DIVSW_BIT];
  wire logic sel_ok = wsel <= orc_pkg::SRC_EXT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_r <= 1'b0;
      stop_idle_r <= 1'b0;
      oe_r <= 1'b0;
      run_sleep_r <= 1'b0;
      dsw_r <= 1'b0;
      sel_sh_r <= 4'h0;
      div_sh_r <= 15'h0000;
      trm_sh_r <= 9'h000;
      sel_r <= 4'h0;
      div_r <= 15'h0000;
      trm_r <= 9'h000;
    end else if (clk_en) begin
      if (ref_wr) begin
        on_r <= pwdata[orc_pkg::ON_BIT];
        stop_idle_r <= pwdata[orc_pkg::STOP_IDLE_BIT];
        oe_r <= pwdata[orc_pkg::OE_BIT];
        run_sleep_r <= pwdata[orc_pkg::RUN_SLEEP_BIT];
        div_sh_r <= wdiv;
        if (sel_ok) begin
          sel_sh_r <= wsel;
        end
      end
      if (trm_wr) begin
        trm_sh_r <= wtrm;
      end
      // divider switch: set by write, cleared once new values are loaded
      if (dsw_r) begin
        dsw_r <= 1'b0;
        sel_r <= sel_sh_r;
        div_r <= div_sh_r;
        trm_r <= trm_sh_r;
      end else if (dsw_req) begin
        dsw_r <= 1'b1;
      end else if (!on_r) begin
        // disabled: new values take effect directly
        sel_r <= sel_sh_r;
        div_r <= div_sh_r;
        trm_r <= trm_sh_r;
      end
    end
  end

  // ==========================================================
  // fractional divider: half period = div + trim/512 source edges
  logic [8:0] src_d_r;
  logic [14:0] cnt_r;
  logic [orc_pkg::ACC_W-1:0] acc_r;
  logic ref_r;
  wire logic src_clk = ref_src_clks[sel_r];
  wire logic src_edge = src_clk & ~src_d_r[sel_r];
  // system and bus clocks stop in sleep, so run-in-sleep cannot keep them
  wire logic clk_src = (sel_r == orc_pkg::SRC_SYS_CLK) | (sel_r == orc_pkg::SRC_PERIPH_CLK);
  wire logic sleep_stop = sleep_mode & (~run_sleep_r | clk_src);
  wire logic run = on_r & ~(idle_mode & stop_idle_r) & ~sleep_stop;
  wire logic [orc_pkg::ACC_W-1:0] acc_sum = acc_r + {1'b0, trm_r};
  wire logic extra = acc_sum[orc_pkg::ACC_W-1];
  wire logic [14:0] half_len = div_r + {14'h0000, extra};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_d_r <= 9'h000;
      cnt_r <= 15'h0000;
      acc_r <= '0;
      ref_r <= 1'b0;
    end else if (clk_en) begin
      src_d_r <= ref_src_clks;
      if (!run) begin
        cnt_r <= 15'h0000;
        acc_r <= '0;
        ref_r <= 1'b0;
      end else if (div_r == 15'h0000) begin
        ref_r <= src_clk;
      end else if (src_edge) begin
        if (cnt_r + 15'h0001 >= half_len) begin
          cnt_r <= 15'h0000;
          ref_r <= ~ref_r;
          acc_r <= {1'b0, acc_sum[orc_pkg::ACC_W-2:0]};
        end else begin
          cnt_r <= cnt_r + 15'h0001;
        end
      end
    end
  end

  // active while enabled and running or a divider switch pending
  wire logic active = on_r & (run | dsw_r);
  assign ref_clock_out_pin = ref_r & oe_r & run;
  assign ref_clock_out_oe_n = ~(oe_r & on_r);

  // ==========================================================
  // read mux; unimplemented bits stay zero
  logic [31:0] osc_rd, tun_rd, ref_rd, trm_rd, sts_rd;
  always_comb begin
    osc_rd = 32'h0000_0000;
    osc_rd[orc_pkg::FAIL_FLAG_BIT] = fail_flag_r;
    osc_rd[orc_pkg::USB_RC_BIT] = usb_rc_r;
    osc_rd[orc_pkg::SOSC_EN_BIT] = sosc_r;
    osc_rd[orc_pkg::OSC_SWITCH_BIT] = osw_r;
    osc_rd[orc_pkg::NEW_OSC_LSB +: orc_pkg::OSC_SEL_W] = new_osc_r;
    osc_rd[orc_pkg::CUR_OSC_LSB +: orc_pkg::OSC_SEL_W] = cur_osc_r;
    tun_rd = {26'h0000000, tun_r};
    ref_rd = 32'h0000_0000;
    ref_rd[orc_pkg::SEL_LSB +: orc_pkg::SEL_W] = sel_sh_r;
    ref_rd[orc_pkg::ACTIVE_BIT] = active;
    ref_rd[orc_pkg::DIVSW_BIT] = dsw_r;
    ref_rd[orc_pkg::RUN_SLEEP_BIT] = run_sleep_r;
    ref_rd[orc_pkg::OE_BIT] = oe_r;
    ref_rd[orc_pkg::STOP_IDLE_BIT] = stop_idle_r;
    ref_rd[orc_pkg::ON_BIT] = on_r;
    ref_rd[orc_pkg::DIV_LSB +: orc_pkg::DIV_W] = div_sh_r;
    trm_rd = 32'h0000_0000;
    trm_rd[orc_pkg::TRIM_LSB +: orc_pkg::TRIM_W] = trm_sh_r;
    sts_rd = {29'h00000000, locked_wr_r, unl_r};
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (hit_osc) prdata = osc_rd;
    if (hit_tun) prdata = tun_rd;
    if (hit_ref) prdata = ref_rd;
    if (hit_trm) prdata = trm_rd;
    if (hit_sts) prdata = sts_rd;
  end
endmodule
`default_nettype wire

// ### orc_top_properties.sv
// port checker for the oscillator and reference clock control block
`timescale 1ns/1ps
`default_nettype none
module orc_top_properties #(
  parameter int SWITCH_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fail_safe_clock_monitor,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  input wire logic [8:0] ref_src_clks,
  input wire logic ref_clock_out_pin,
  input wire logic ref_clock_out_oe_n,
  input wire logic usb_clock_from_rc_select,
  input wire logic secondary_osc_enable,
  input wire logic [5:0] rc_trim_field,
  input wire logic [2:0] osc_select,
  input wire logic osc_switch_pulse
);
  // ==========================================
  // access decode
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && clk_en;
  wire logic wr_osc = acc && pwrite && paddr == orc_pkg::ADDR_OSC_CTRL;
  wire logic wr_tun = acc && pwrite && paddr == orc_pkg::ADDR_RC_TUNE;
  wire logic mapped = paddr inside {8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h44};
  sequence pulse_s;
    osc_switch_pulse ##1 !osc_switch_pulse;
  endsequence
  // ==========================================
  // properties
  pready_high_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  pin_gated_a: assert property (ref_clock_out_oe_n |-> !ref_clock_out_pin)
    else $error("pin toggles while not driven");
  tune_write_a: assert property ($changed(rc_trim_field) |-> $past(wr_tun) &&
    rc_trim_field == $past(pwdata[5:0])) else $error("trim changed without write");
  sosc_write_a: assert property ($changed(secondary_osc_enable) |-> $past(wr_osc) &&
    secondary_osc_enable == $past(pwdata[1])) else $error("sosc enable changed alone");
  usb_write_a: assert property ($changed(usb_clock_from_rc_select) |-> $past(wr_osc) &&
    usb_clock_from_rc_select == $past(pwdata[2])) else $error("usb select changed alone");
  pulse_once_a: assert property (osc_switch_pulse |-> pulse_s)
    else $error("switch pulse too long");
  sel_on_pulse_a: assert property ($changed(osc_select) |->
    osc_switch_pulse || $past(osc_switch_pulse)) else $error("select moved without switch");
endmodule
bind orc_top orc_top_properties #(.SWITCH_CYCLES(SWITCH_CYCLES)) u_orc_top_properties (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fail_safe_clock_monitor(fail_safe_clock_monitor),
  .idle_mode(idle_mode), .sleep_mode(sleep_mode), .ref_src_clks(ref_src_clks),
  .ref_clock_out_pin(ref_clock_out_pin), .ref_clock_out_oe_n(ref_clock_out_oe_n),
  .usb_clock_from_rc_select(usb_clock_from_rc_select),
  .secondary_osc_enable(secondary_osc_enable), .rc_trim_field(rc_trim_field),
  .osc_select(osc_select), .osc_switch_pulse(osc_switch_pulse));
`default_nettype wire

// ### testbench.sv
// self-checking bench for the oscillator and reference clock control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================
  // stimulus and design
  logic pclk, presetn, clk_en, psel, penable, pwrite, fail_mon, idle_mode, sleep_mode;
  logic pready, pslverr, pin, oe_n, usb, sosc, pulse, pin_q, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] tune;
  logic [2:0] osel;
  logic [1:0] sc;
  int failures, n_tests, edges;
  orc_top #(.SWITCH_CYCLES(4)) u_orc_top (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fail_safe_clock_monitor(fail_mon), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .ref_src_clks({9{sc[1]}}), .ref_clock_out_pin(pin),
    .ref_clock_out_oe_n(oe_n), .usb_clock_from_rc_select(usb),
    .secondary_osc_enable(sosc), .rc_trim_field(tune), .osc_select(osel),
    .osc_switch_pulse(pulse));
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // every source runs at a quarter of pclk, slow enough to be sampled
  always @(posedge pclk) begin
    sc <= sc + 2'h1;
    pin_q <= pin;
    if (pin && !pin_q) edges++;
  end
  // ==========================================
  // tasks
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk("read data", exp, rd);
  endtask
  task unlock;
    xfer(1'b1, orc_pkg::ADDR_UNLOCK, orc_pkg::UNLOCK_KEY1);
    xfer(1'b1, orc_pkg::ADDR_UNLOCK, orc_pkg::UNLOCK_KEY2);
  endtask
  task rate(input int lo, input int hi);
    edges = 0;
    repeat (96) @(posedge pclk);
    chk("edge count in range", 32'h1, 32'(edges >= lo && edges <= hi));
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    final_report();
  end
  // ==========================================
  // tests
  initial begin
    presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
    pwdata = 32'h0; fail_mon = 0; idle_mode = 0; sleep_mode = 0; sc = 2'h0; pin_q = 0;
    failures = 0; n_tests = 0; edges = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rdchk(8'(i * 16), 32'h0);
    xfer(1'b1, 8'h10, 32'hffff_ffff);
    rdchk(8'h10, 32'h0);
    xfer(1'b0, 8'h44, 32'h0);
    chk("dropped flag", 32'h4, rd & 32'h4);
    unlock();
    xfer(1'b1, 8'h10, 32'hffff_ffff);
    rdchk(8'h10, 32'h3f);
    chk("trim pin", 32'h3f, 32'(tune));
    $display("test lock and tuning done");
    unlock();
    xfer(1'b1, 8'h00, 32'h0000_0507);
    rdchk(8'h00, 32'h0000_0507);
    for (int i = 0; i < 20 && pulse !== 1'b1; i++) @(posedge pclk);
    chk("switch pulse", 32'h1, 32'(pulse));
    @(posedge pclk);
    chk("new osc", 32'h5, 32'(osel));
    rdchk(8'h00, 32'h0000_5506);
    chk("usb and sosc", 32'h3, 32'({usb, sosc}));
    fail_mon <= 1'b1;
    @(posedge pclk);
    fail_mon <= 1'b0;
    rdchk(8'h00, 32'h0000_550e);
    $display("test oscillator switch done");
    xfer(1'b1, 8'h20, 32'h0001_0003);
    xfer(1'b1, 8'h20, 32'h0001_9003);
    rate(11, 13);
    chk("oe pin", 32'h0, 32'(oe_n));
    xfer(1'b1, 8'h20, 32'h0003_9003);
    rate(11, 13);
    xfer(1'b1, 8'h20, 32'h0003_9203);
    @(posedge pclk);
    rdchk(8'h20, 32'h0003_9103);
    rate(3, 5);
    xfer(1'b1, 8'h20, 32'h0003_b003);
    idle_mode <= 1'b1;
    rate(0, 0);
    idle_mode <= 1'b0;
    sleep_mode <= 1'b1;
    xfer(1'b1, 8'h20, 32'h0003_9003);
    rate(0, 0);
    xfer(1'b1, 8'h20, 32'h0003_1000);
    rdchk(8'h20, 32'h0003_1000);
    xfer(1'b1, 8'h20, 32'h0003_9800);
    rate(0, 0);
    sleep_mode <= 1'b0;
    xfer(1'b1, 8'h20, 32'h0003_8000);
    rate(0, 0);
    $display("test reference generator done");
    xfer(1'b1, 8'h30, 32'hffff_ffff);
    rdchk(8'h30, 32'hff80_0000);
    xfer(1'b0, 8'h50, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    $display("test trim and unmapped done");
    final_report();
  end
endmodule
`default_nettype wire
